// ===== logic/vli_pkg.sv
// package of the local interrupt status block: offsets, field layout, reset values
// assumes a 16-bit configuration space addressed by byte offset
`default_nettype none
package vli_pkg;
    localparam int unsigned        OFF_W         = 6;
    localparam logic [OFF_W-1:0]   OFF_LA_REG    = 6'h00;
    localparam logic [OFF_W-1:0]   OFF_IRQ_STAT  = 6'h2a;

    // status word fields
    localparam int unsigned        ST_LVL_HI     = 15;
    localparam int unsigned        ST_LVL_LO     = 13;
    localparam int unsigned        ST_AF_PEND    = 12;
    localparam int unsigned        ST_DEADLOCK_BACKOFF_FLAG      = 11;
    localparam int unsigned        ST_RSVD       = 10;
    localparam int unsigned        ST_SF_LIVE    = 9;
    localparam int unsigned        ST_AF_LIVE    = 8;
    localparam int unsigned        ST_SF_PEND    = 7;
    localparam int unsigned        ST_IRQ_HI     = 6;

    // control word fields
    localparam int unsigned        CT_LVL_HI     = 15;
    localparam int unsigned        CT_LVL_LO     = 13;
    localparam int unsigned        CT_BACKOFF_IRQ_ENABLE    = 11;
    localparam int unsigned        CT_SYS_FAIL_IRQ_ENABLE       = 9;
    localparam int unsigned        CT_POWER_FAIL_IRQ_ENABLE       = 8;

    localparam int unsigned        BE_HI         = 1;
    localparam int unsigned        NUM_IRQ       = 7;
    localparam int unsigned        SYNC_W        = 9;
    localparam int unsigned        SYNC_SF       = 7;
    localparam int unsigned        SYNC_AF       = 8;

    localparam logic [2:0]         LVL_OFF       = 3'h0;
    localparam logic [15:0]        WORD_ZERO     = 16'h0000;
    localparam logic [7:0]         BYTE_ZERO     = 8'h00;
    localparam logic [NUM_IRQ:1]   IRQ_OE_IDLE   = 7'h7f;

    typedef logic [2:0] vli_level_t;
endpackage
`default_nettype wire

// ===== logic/vli_sync_if.sv
// carrier between the top and its pin synchroniser
// assumes both ends run on the single block clock
`default_nettype none
interface vli_sync_if #(parameter int unsigned W = 9);
    logic [W-1:0] raw;
    logic [W-1:0] level;
    modport sync (input raw, output level);
    modport user (output raw, input level);
endinterface
`default_nettype wire

// ===== logic/vli_pin_sync.sv
// three-stage pin synchroniser; a change counts once stages two and three agree
// assumes asynchronous raw inputs, already converted to active-high
`default_nettype none
module vli_pin_sync
    import vli_pkg::*;
#(
    parameter int unsigned W = SYNC_W
)(
    input  wire logic  mclk_in,
    input  wire logic  nrst_in,
    vli_sync_if.sync   sif
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] lvl_r;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= sif.raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // first stage is read only by the second; filtering starts at stage two
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge mclk_in) begin
                if (!nrst_in) begin
                    lvl_r[g] <= 1'b0;
                end else if (s2_r[g] == s3_r[g]) begin
                    lvl_r[g] <= s3_r[g];
                end
            end
        end
    endgenerate

    assign sif.level = lvl_r;
endmodule
`default_nettype wire

// ===== logic/vli_irq_status.sv
// local interrupt status and level drive of the bus interface module
// assumes one 25 MHz clock, pin inputs asynchronous, config port and deadlock
// pulse from logic on the same clock
// Overview of operation
// - acknowledge answer is status high byte plus own logical address low byte
// - status bits 15-13 read back the written local interrupt level
// - status bit 12 is set while driving the level because of power fail
// - status bit 7 is set while driving the level because of system fail
// - both fail pending flags clear when we answer our acknowledge
// - status bit 11 latches a deadlock even with its interrupt disabled
// - deadlock flag with its enable set raises the local interrupt
// - deadlock flag clears on a status read or our acknowledge
// - status bit 10 always reads zero
// - status bit 9 shows live system fail, one when the line is low
// - system fail asserting with its enable set raises the local interrupt
// - status bit 8 shows live power fail, one when the line is low
// - power fail asserting with its enable set raises the local interrupt
// - status bits 6-0 show live request lines seven down to one
// - level field picks request line one to seven; zero disables locally
// - level and enables clear on hard reset, soft reset keeps them
// - acknowledge low byte is the own address, also readable in its register
`default_nettype none
module vli_irq_status
    import vli_pkg::*;
(
    input  wire logic                mclk_in,
    input  wire logic                nrst_in,
    input  wire logic                soft_rst_in,
    input  wire logic [7:0]          own_logical_address_in,
    input  wire logic [NUM_IRQ:1]    irq_n_in,
    input  wire logic                sysfail_n_in,
    input  wire logic                acfail_n_in,
    input  wire logic                deadlock_in,
    input  wire logic                cfg_rd_in,
    input  wire logic                cfg_wr_in,
    input  wire logic [OFF_W-1:0]    cfg_off_in,
    input  wire logic [1:0]          cfg_be_in,
    input  wire logic [15:0]         cfg_wdata_in,
    input  wire logic                iack_in,
    input  wire logic [2:0]          iack_level_in,
    output logic [15:0]              cfg_rdata_out,
    output logic                     cfg_ack_out,
    output logic                     iack_ack_out,
    output logic [15:0]              iack_vector_out,
    output logic [NUM_IRQ:1]         irq_drv_out,
    output logic [NUM_IRQ:1]         irq_oe_n_out
);
    vli_level_t        local_irq_level_r;
    logic              backoff_irq_enable_r;
    logic              sys_fail_irq_enable_r;
    logic              power_fail_irq_enable_r;
    logic              sys_fail_irq_pending_r;
    logic              power_fail_irq_pending_r;
    logic              deadlock_backoff_flag_r;
    logic              sf_prev_r;
    logic              af_prev_r;
    logic [15:0]       cfg_rdata_r;
    logic              cfg_ack_r;
    logic              iack_ack_r;
    logic [15:0]       iack_vector_r;
    logic [NUM_IRQ:1]  irq_oe_n_r;
    logic [NUM_IRQ:1]  irq_live;
    logic              sf_live;
    logic              af_live;
    logic              sf_rise;
    logic              af_rise;
    logic              local_req;
    logic              iack_ours;
    logic              stat_rd;
    logic              ctl_wr;
    logic [15:0]       interrupt_status;

    vli_sync_if #(.W(SYNC_W)) sif ();

    ////////////////////////////////////////////////////////////////////////
    // pins are active low; invert before the synchroniser so level means asserted
    assign sif.raw = {~acfail_n_in, ~sysfail_n_in, ~irq_n_in};

    vli_pin_sync #(.W(SYNC_W)) u_sync (
        .mclk_in (mclk_in),
        .nrst_in (nrst_in),
        .sif     (sif)
    );

    assign irq_live = sif.level[NUM_IRQ-1:0];
    assign sf_live  = sif.level[SYNC_SF];
    assign af_live  = sif.level[SYNC_AF];
    assign sf_rise  = sf_live && !sf_prev_r;
    assign af_rise  = af_live && !af_prev_r;

    ////////////////////////////////////////////////////////////////////////
    // decode
    assign stat_rd   = cfg_rd_in && (cfg_off_in == OFF_IRQ_STAT) && cfg_be_in[BE_HI];
    assign ctl_wr    = cfg_wr_in && (cfg_off_in == OFF_IRQ_STAT) && cfg_be_in[BE_HI];
    // level zero disables locally, so pending flags alone never drive a line
    assign local_req = (local_irq_level_r != LVL_OFF)
                    && (sys_fail_irq_pending_r || power_fail_irq_pending_r
                        || (deadlock_backoff_flag_r && backoff_irq_enable_r));
    assign iack_ours = iack_in && local_req && (iack_level_in == local_irq_level_r);

    always_comb begin
        interrupt_status                        = WORD_ZERO;
        interrupt_status[ST_LVL_HI:ST_LVL_LO]   = local_irq_level_r;
        interrupt_status[ST_AF_PEND]            = power_fail_irq_pending_r;
        interrupt_status[ST_DEADLOCK_BACKOFF_FLAG]              = deadlock_backoff_flag_r;
        interrupt_status[ST_RSVD]               = 1'b0;
        interrupt_status[ST_SF_LIVE]            = sf_live;
        interrupt_status[ST_AF_LIVE]            = af_live;
        interrupt_status[ST_SF_PEND]            = sys_fail_irq_pending_r;
        interrupt_status[ST_IRQ_HI:0]           = irq_live;
    end

    ////////////////////////////////////////////////////////////////////////
    // control: hard reset only, soft reset leaves it alone
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            local_irq_level_r       <= LVL_OFF;
            backoff_irq_enable_r    <= 1'b0;
            sys_fail_irq_enable_r   <= 1'b0;
            power_fail_irq_enable_r <= 1'b0;
        end else if (ctl_wr) begin
            local_irq_level_r       <= cfg_wdata_in[CT_LVL_HI:CT_LVL_LO];
            backoff_irq_enable_r    <= cfg_wdata_in[CT_BACKOFF_IRQ_ENABLE];
            sys_fail_irq_enable_r   <= cfg_wdata_in[CT_SYS_FAIL_IRQ_ENABLE];
            power_fail_irq_enable_r <= cfg_wdata_in[CT_POWER_FAIL_IRQ_ENABLE];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            sf_prev_r <= 1'b0;
            af_prev_r <= 1'b0;
        end else begin
            sf_prev_r <= sf_live;
            af_prev_r <= af_live;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pending flags: a new event in the clearing cycle wins over the clear
    always_ff @(posedge mclk_in) begin
        if (!nrst_in || soft_rst_in) begin
            sys_fail_irq_pending_r <= 1'b0;
        end else if (sf_rise && sys_fail_irq_enable_r
                     && local_irq_level_r != LVL_OFF) begin
            sys_fail_irq_pending_r <= 1'b1;
        end else if (iack_ours) begin
            sys_fail_irq_pending_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!nrst_in || soft_rst_in) begin
            power_fail_irq_pending_r <= 1'b0;
        end else if (af_rise && power_fail_irq_enable_r
                     && local_irq_level_r != LVL_OFF) begin
            power_fail_irq_pending_r <= 1'b1;
        end else if (iack_ours) begin
            power_fail_irq_pending_r <= 1'b0;
        end
    end

    // deadlock is stored whatever its enable says
    always_ff @(posedge mclk_in) begin
        if (!nrst_in || soft_rst_in) begin
            deadlock_backoff_flag_r <= 1'b0;
        end else if (deadlock_in) begin
            deadlock_backoff_flag_r <= 1'b1;
        end else if (stat_rd || iack_ours) begin
            deadlock_backoff_flag_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration reads and writes answer one cycle later
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            cfg_rdata_r <= WORD_ZERO;
            cfg_ack_r   <= 1'b0;
        end else begin
            cfg_ack_r <= cfg_rd_in || cfg_wr_in;
            if (cfg_rd_in && cfg_off_in == OFF_IRQ_STAT) begin
                cfg_rdata_r <= interrupt_status;
            end else if (cfg_rd_in && cfg_off_in == OFF_LA_REG) begin
                cfg_rdata_r <= {BYTE_ZERO, own_logical_address_in};
            end else if (cfg_rd_in) begin
                cfg_rdata_r <= WORD_ZERO;
            end
        end
    end

    // acknowledge: only answered at our own level while we request
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            iack_ack_r    <= 1'b0;
            iack_vector_r <= WORD_ZERO;
        end else begin
            iack_ack_r <= iack_ours;
            if (iack_ours) begin
                iack_vector_r <= {interrupt_status[ST_LVL_HI:ST_AF_LIVE],
                                  own_logical_address_in};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // open-drain drive: enable low pulls the selected line; lags flags by a cycle
    genvar g;
    generate
        for (g = 1; g <= NUM_IRQ; g++) begin : g_line
            always_ff @(posedge mclk_in) begin
                if (!nrst_in) begin
                    irq_oe_n_r[g] <= 1'b1;
                end else begin
                    irq_oe_n_r[g] <= !(local_req
                        && local_irq_level_r == 3'(g));
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            irq_drv_out <= '0;
        end else begin
            irq_drv_out <= '0;
        end
    end

    assign cfg_rdata_out   = cfg_rdata_r;
    assign cfg_ack_out     = cfg_ack_r;
    assign iack_ack_out    = iack_ack_r;
    assign iack_vector_out = iack_vector_r;
    assign irq_oe_n_out    = irq_oe_n_r;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);

    property p_iack_vec;
        iack_ours |=> iack_ack_out
            && iack_vector_out[7:0] == $past(own_logical_address_in)
            && iack_vector_out[15:13] == $past(local_irq_level_r);
    endproperty
    a_iack_vec: assert property (p_iack_vec) else $error("bad acknowledge vector");

    property p_lvl_read;
        cfg_rd_in && cfg_off_in == OFF_IRQ_STAT && !ctl_wr
            |=> cfg_rdata_out[15:13] == $past(local_irq_level_r);
    endproperty
    a_lvl_read: assert property (p_lvl_read) else $error("level readback wrong");

    property p_rsvd;
        cfg_ack_out |-> !cfg_rdata_out[ST_RSVD];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

    property p_clear_on_iack;
        iack_ours && !sf_rise && !af_rise && !deadlock_in && !soft_rst_in
            |=> !sys_fail_irq_pending_r && !power_fail_irq_pending_r
                && !deadlock_backoff_flag_r;
    endproperty
    a_clear_on_iack: assert property (p_clear_on_iack) else $error("flags kept");

    property p_deadlock_backoff_flag_sticky;
        deadlock_in && !soft_rst_in |=> deadlock_backoff_flag_r;
    endproperty
    a_deadlock_backoff_flag_sticky: assert property (p_deadlock_backoff_flag_sticky) else $error("deadlock lost");

    property p_deadlock_backoff_flag_rdclr;
        stat_rd && !deadlock_in |=> !deadlock_backoff_flag_r;
    endproperty
    a_deadlock_backoff_flag_rdclr: assert property (p_deadlock_backoff_flag_rdclr) else $error("read did not clear");

    property p_sf_irq;
        sf_rise && sys_fail_irq_enable_r && local_irq_level_r != LVL_OFF
            && !soft_rst_in && !ctl_wr
            |=> ##1 !irq_oe_n_out[local_irq_level_r];
    endproperty
    a_sf_irq: assert property (p_sf_irq) else $error("sysfail not driven");

    property p_af_irq;
        af_rise && power_fail_irq_enable_r && local_irq_level_r != LVL_OFF
            && !soft_rst_in && !ctl_wr
            |=> power_fail_irq_pending_r ##1 !irq_oe_n_out[local_irq_level_r];
    endproperty
    a_af_irq: assert property (p_af_irq) else $error("acfail not driven");

    property p_off_silent;
        local_irq_level_r == LVL_OFF |=> irq_oe_n_out == IRQ_OE_IDLE;
    endproperty
    a_off_silent: assert property (p_off_silent) else $error("drive at level 0");

    property p_release;
        !local_req |=> irq_oe_n_out == IRQ_OE_IDLE;
    endproperty
    a_release: assert property (p_release) else $error("line not released");

    c_iack:   cover property (iack_ours ##1 iack_ack_out);
    c_deadlock_backoff_flag:  cover property (deadlock_in ##[1:20] stat_rd);
    c_sf_ack: cover property (sf_rise ##[1:30] iack_ours);
    c_race:   cover property (deadlock_in && stat_rd);
endmodule
`default_nettype wire

// ===== verif/vli_iack_model.sv
// bus interrupt handler model: acknowledges the highest request line seen low
// assumes the bench enables it, sets its delay, and wires the pulled-up lines
`default_nettype none
module vli_iack_model
    import vli_pkg::*;
(
    input  wire logic             mclk_in,
    input  wire logic             nrst_in,
    input  wire logic             en_in,
    input  wire logic [3:0]       wait_in,
    input  wire logic [NUM_IRQ:1] irq_line_n_in,
    input  wire logic             ack_in,
    input  wire logic [15:0]      vector_in,
    output logic                  iack_out,
    output logic [2:0]            level_out,
    output logic [15:0]           vector_out,
    output logic                  done_out
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////
    // handler changes its strobes on the falling edge only
    initial begin
        iack_out   = 1'b0;
        level_out  = 3'h0;
        vector_out = 16'h0000;
        done_out   = 1'b0;
        forever begin
            @(negedge mclk_in);
            done_out = 1'b0;
            if (en_in && nrst_in && irq_line_n_in !== IRQ_OE_IDLE) begin
                for (int i = 1; i <= NUM_IRQ; i++) begin
                    if (irq_line_n_in[i] === 1'b0) begin
                        level_out = 3'(i);
                    end
                end
                repeat (wait_in) @(negedge mclk_in);
                iack_out = 1'b1;
                @(negedge mclk_in);
                iack_out = 1'b0;
                // the answer stands one cycle only; a missing one leaves done low
                if (ack_in === 1'b1) begin
                    vector_out = vector_in;
                    done_out   = 1'b1;
                    // done holds until the bench drops enable, so no race on one edge
                    wait (!en_in);
                    done_out   = 1'b0;
                end
                // line release lags the answer, so do not look again at once
                repeat (2) @(negedge mclk_in);
            end
        end
    end
endmodule
`default_nettype wire

// ===== verif/vli_irq_status_test.sv
// self-checking bench of the local interrupt status block
// assumes the handler model issues acknowledges; request lines are pulled up
`default_nettype none
module vli_irq_status_test;
    import vli_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] LA = 8'h5c;
    logic mclk_in, nrst, soft_rst, sysfail_n, acfail_n, deadlock, en;
    logic cfg_rd, cfg_wr, iack, cfg_ack, iack_ack, done;
    logic [NUM_IRQ:1] irq_n_tb, oe_n, drv, line_n;
    logic [5:0] cfg_off;
    logic [1:0] cfg_be;
    logic [2:0] iack_lvl;
    logic [3:0] wt;
    logic [15:0] cfg_wd, rdata, vec, vec_seen, tmp;
    int fail_count, cmp_count, cyc;
    // open-drain lines: anyone pulling low wins
    assign line_n = oe_n & irq_n_tb;
    vli_irq_status vli_irq_status_i (.mclk_in(mclk_in), .nrst_in(nrst), .soft_rst_in(soft_rst),
        .own_logical_address_in(LA), .irq_n_in(line_n), .sysfail_n_in(sysfail_n),
        .acfail_n_in(acfail_n), .deadlock_in(deadlock), .cfg_rd_in(cfg_rd),
        .cfg_wr_in(cfg_wr), .cfg_off_in(cfg_off), .cfg_be_in(cfg_be), .cfg_wdata_in(cfg_wd),
        .iack_in(iack), .iack_level_in(iack_lvl), .cfg_rdata_out(rdata),
        .cfg_ack_out(cfg_ack), .iack_ack_out(iack_ack), .iack_vector_out(vec),
        .irq_drv_out(drv), .irq_oe_n_out(oe_n));
    vli_iack_model vli_iack_model_i (.mclk_in(mclk_in), .nrst_in(nrst), .en_in(en),
        .wait_in(wt), .irq_line_n_in(line_n), .ack_in(iack_ack), .vector_in(vec),
        .iack_out(iack), .level_out(iack_lvl), .vector_out(vec_seen), .done_out(done));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 6000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // config access: strobe one cycle, answer registered on the same edge that takes it
    task automatic cfg(input logic wr, input logic [5:0] off, input logic [1:0] be,
                       input logic [15:0] wd, output logic [15:0] rd);
        cfg_rd = !wr; cfg_wr = wr; cfg_off = off; cfg_be = be; cfg_wd = wd;
        @(negedge mclk_in);
        // ack stands one cycle only, so look before the next edge
        check({15'h0, cfg_ack}, 16'h0001);
        rd = rdata;
        cfg_rd = 1'b0; cfg_wr = 1'b0;
        @(negedge mclk_in);
    endtask
    task automatic wr(input logic [15:0] d);
        cfg(1'b1, OFF_IRQ_STAT, 2'b11, d, tmp);
    endtask
    task automatic rd_chk(input logic [5:0] off, input logic [15:0] exp);
        cfg(1'b0, off, 2'b11, 16'h0000, tmp);
        check(tmp, exp);
    endtask
    task automatic wait_drive(input int lvl);
        for (int n = 0; n < 20 && oe_n[lvl] !== 1'b0; n++) @(negedge mclk_in);
        check(16'(oe_n), 16'(7'h7f ^ (7'h01 << (lvl - 1))));
        // our own pull reaches the live bits only after the pin synchroniser
        repeat (6) @(negedge mclk_in);
    endtask
    task automatic handler(input logic [3:0] w, input logic [15:0] exp_vec);
        wt = w; en = 1'b1;
        for (int n = 0; n < 40 && done !== 1'b1; n++) @(negedge mclk_in);
        en = 1'b0;
        check(vec_seen, exp_vec);
        repeat (8) @(negedge mclk_in);
        check(16'(oe_n), 16'h007f);
    endtask
    task automatic pulse_dl();
        deadlock = 1'b1;
        @(negedge mclk_in);
        deadlock = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_plain();
        rd_chk(OFF_IRQ_STAT, 16'h0000);
        rd_chk(OFF_LA_REG, {8'h00, LA});
        rd_chk(6'h10, 16'h0000);
        check(16'(drv), 16'h0000);
        for (int l = 1; l <= 7; l++) begin
            wr({3'(l), 13'h0});
            rd_chk(OFF_IRQ_STAT, {3'(l), 13'h0});
        end
        cfg(1'b1, OFF_IRQ_STAT, 2'b01, 16'h0000, tmp);
        rd_chk(OFF_IRQ_STAT, 16'he000);
    endtask
    task automatic t_live();
        wr(16'h0b00);
        irq_n_tb = 7'h55; sysfail_n = 1'b0; acfail_n = 1'b0;
        repeat (10) @(negedge mclk_in);
        rd_chk(OFF_IRQ_STAT, 16'h032a);
        check(16'(oe_n), 16'h007f);
        irq_n_tb = 7'h7f; sysfail_n = 1'b1; acfail_n = 1'b1;
        repeat (10) @(negedge mclk_in);
    endtask
    task automatic t_sysfail();
        wr(16'ha200);
        sysfail_n = 1'b0;
        wait_drive(5);
        rd_chk(OFF_IRQ_STAT, 16'ha290);
        handler(4'h0, {8'ha2, LA});
        rd_chk(OFF_IRQ_STAT, 16'ha200);
        sysfail_n = 1'b1;
        repeat (8) @(negedge mclk_in);
    endtask
    task automatic t_acfail();
        wr(16'h4100);
        acfail_n = 1'b0;
        wait_drive(2);
        rd_chk(OFF_IRQ_STAT, 16'h5102);
        handler(4'h5, {8'h51, LA});
        rd_chk(OFF_IRQ_STAT, 16'h4100);
        acfail_n = 1'b1;
        repeat (8) @(negedge mclk_in);
    endtask
    task automatic t_deadlock();
        wr(16'he000);
        pulse_dl();
        repeat (3) @(negedge mclk_in);
        check(16'(oe_n), 16'h007f);
        rd_chk(OFF_IRQ_STAT, 16'he800);
        rd_chk(OFF_IRQ_STAT, 16'he000);
        wr(16'he800);
        pulse_dl();
        wait_drive(7);
        handler(4'h2, {8'he8, LA});
        rd_chk(OFF_IRQ_STAT, 16'he000);
        // a clearing read alone must also let the line go
        pulse_dl();
        wait_drive(7);
        rd_chk(OFF_IRQ_STAT, 16'he840);
        repeat (8) @(negedge mclk_in);
        check(16'(oe_n), 16'h007f);
        rd_chk(OFF_IRQ_STAT, 16'he000);
    endtask
    task automatic t_resets();
        wr(16'ha200);
        sysfail_n = 1'b0;
        wait_drive(5);
        soft_rst = 1'b1;
        @(negedge mclk_in);
        soft_rst = 1'b0;
        repeat (8) @(negedge mclk_in);
        rd_chk(OFF_IRQ_STAT, 16'ha200);
        check(16'(oe_n), 16'h007f);
        sysfail_n = 1'b1;
        repeat (8) @(negedge mclk_in);
        // enables survive the soft reset, so a fresh fall drives again
        sysfail_n = 1'b0;
        wait_drive(5);
        sysfail_n = 1'b1;
        nrst = 1'b0;
        repeat (3) @(negedge mclk_in);
        nrst = 1'b1;
        repeat (8) @(negedge mclk_in);
        check(16'(oe_n), 16'h007f);
        rd_chk(OFF_IRQ_STAT, 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        fail_count = 0; cmp_count = 0; cyc = 0;
        nrst = 1'b0; soft_rst = 1'b0; sysfail_n = 1'b1; acfail_n = 1'b1;
        deadlock = 1'b0; en = 1'b0; wt = 4'h0; irq_n_tb = 7'h7f;
        cfg_rd = 1'b0; cfg_wr = 1'b0; cfg_off = 6'h00; cfg_be = 2'b00; cfg_wd = 16'h0000;
        repeat (3) @(negedge mclk_in);
        nrst = 1'b1;
        repeat (6) @(negedge mclk_in);
        t_plain();
        t_live();
        t_sysfail();
        t_acfail();
        t_deadlock();
        t_resets();
        end_of_test();
    end
endmodule
`default_nettype wire
